// file: core/cmcs_buf.sv
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cmcs_buf
   import cmcs_pkg::*;
#(
   parameter int WIDTH = WORD_W,
   parameter int DEPTH = BUF_DEPTH
) (
   input wire logic clk, // system clock
   input wire logic rst, // sync reset, high
   cmcs_stream_if.snk fill, // words in
   cmcs_stream_if.src drain // words out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_ONE = PW'(1);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH != $bits(fill.data)) begin : g_chk
      $error("buffer depth must be a power of two, width must match");
   end

   logic [WIDTH-1:0] mem [DEPTH]; // storage
   logic [PW-1:0] wr_ptr; // next slot to fill
   logic [PW-1:0] rd_ptr; // oldest slot
   logic [CW-1:0] count; // words held
   logic push;
   logic pop;

   // full refuses, empty offers nothing
   assign fill.ready = (count != CNT_FULL);
   assign drain.valid = (count != '0);
   assign drain.data = mem[rd_ptr];
   assign push = fill.valid && fill.ready;
   assign pop = drain.valid && drain.ready;

   // storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= fill.data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + PTR_ONE;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + PTR_ONE;
         end
         if (push && !pop) begin
            count <= count + CNT_ONE;
         end else if (pop && !push) begin
            count <= count - CNT_ONE;
         end
      end
   end

   default clocking bdc @(posedge clk); endclocking
   default disable iff (rst);
   full_refuse_a: assert property (count == CNT_FULL |-> !fill.ready ##0 drain.valid)
      else $error("full buffer still accepts");
   no_loss_a: assert property (push && !pop |=> count == $past(count) + CNT_ONE)
      else $error("accepted word not counted");
endmodule
`default_nettype wire

// file: core/cmcs_clk_gen.sv
// master config clock generator: divider or external source, clean rate changes
`timescale 1ns/1ps
`default_nettype none
module cmcs_clk_gen
   import cmcs_pkg::*;
(
   input wire logic clk, // system clock, stands in for the oscillator
   input wire logic rst, // sync reset, high
   input wire logic run, // advance the clock, low stalls it
   input wire logic use_ext, // follow the external master clock
   input wire logic ext_level, // filtered external master clock
   input wire logic rate_load, // pulse: rate read from the bitstream
   input wire logic [RATE_W-1:0] rate_mhz, // programmed rate, zero = default
   output logic clk_out, // generated clock level
   output logic rise // one-cycle pulse after each rising edge
);
   logic [HALF_W-1:0] half; // half period in use
   logic [HALF_W-1:0] pend_half; // half period waiting for a boundary
   logic pend; // a new rate is waiting
   logic [HALF_W-1:0] cnt; // cycles left in this phase
   logic ext_sel; // source in use, changes at a period end or while stalled with the clock low
   logic toggle; // clock level flips this cycle
   logic period_end; // falling edge, end of a whole period
   logic rate_seen; // helper: a rate has been loaded

   // flip on count expiry, or track the external level
   always_comb begin
      toggle = run && (ext_sel ? (ext_level != clk_out) : (cnt == '0));
   end
   assign period_end = toggle && clk_out;

   // clock level and edge strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         clk_out <= 1'b0;
         rise <= 1'b0;
      end else begin
         rise <= toggle && !clk_out;
         if (toggle) begin
            clk_out <= !clk_out;
         end
      end
   end

   // phase counter; reload picks up a pending rate only at a period end
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= INIT_HALF - 8'h01;
      end else if (toggle) begin
         cnt <= ((period_end && pend) ? pend_half : half) - 8'h01;
      end else if (run && !ext_sel) begin
         cnt <= cnt - 8'h01;
      end
   end

   // rate: start slow, switch after the bitstream names a rate
   always_ff @(posedge clk) begin
      if (rst) begin
         half <= INIT_HALF;
         pend_half <= INIT_HALF;
         pend <= 1'b0;
         rate_seen <= 1'b0;
      end else begin
         if (period_end && pend) begin
            half <= pend_half;
            pend <= 1'b0;
         end
         if (rate_load) begin
            pend_half <= cmcs_half(rate_mhz);
            pend <= 1'b1;
            rate_seen <= 1'b1;
         end
      end
   end

   // source select follows the request at the next period end, or while stalled with the clock low
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_sel <= 1'b0;
      end else if (period_end || (!clk_out && !run)) begin
         ext_sel <= use_ext;
      end
   end

   default clocking gdc @(posedge clk); endclocking
   default disable iff (rst);
   init_rate_a: assert property (!rate_seen |-> half == INIT_HALF)
      else $error("clock left the start rate early");
   rate_apply_a: assert property (period_end && pend |=> half == $past(pend_half))
      else $error("programmed rate not applied");
   clean_edge_a: assert property ($changed(clk_out) && !$past(ext_sel) |-> $past(cnt) == '0)
      else $error("internal clock phase cut short");
   switch_bound_a: assert property ($changed(half) |-> $past(period_end))
      else $error("rate changed inside a period");
endmodule
`default_nettype wire

// file: core/cmcs_pkg.sv
// shared constants, types and helpers of the configuration mode and clock front end
package cmcs_pkg;
   localparam int CLK_MHZ = 25; // system clock rate
   localparam int CLK_PERIOD_NS = 40; // system clock period
   localparam int INIT_RATE_MHZ = 1; // master clock rate at the start of a load
   localparam int DEFAULT_RATE_MHZ = 2; // rate when the bitstream names none
   localparam int RATE_W = 8; // width of the rate setting, in MHz
   localparam int HALF_W = 8; // width of a half-period count
   localparam int WORD_W = 16; // assembled word width
   localparam int SYNC_SETTLE = 4; // cycles before the mode pins are trusted
   localparam int BUF_DEPTH = 2; // entries of the word buffer

   // mode pin encodings; serial and serial-flash share one, parallel likewise
   localparam logic [1:0] MODE_PINS_MPAR = 2'h0;
   localparam logic [1:0] MODE_PINS_MSER = 2'h1;
   localparam logic [1:0] MODE_PINS_SPAR = 2'h2;
   localparam logic [1:0] MODE_PINS_SSER = 2'h3;

   // bus width selects: serial x1/x2/x4, parallel x8/x16
   localparam logic [1:0] BW_X1 = 2'h0;
   localparam logic [1:0] BW_X2 = 2'h1;
   localparam logic [1:0] BW_X4 = 2'h2;
   localparam logic [1:0] BW_X16 = 2'h1;
   localparam logic [4:0] WORD_BITS = 5'h10; // bits in a full word

   typedef enum logic [2:0] {
      CMCS_JTAG = 3'h0,
      CMCS_MSER = 3'h1,
      CMCS_SSER = 3'h2,
      CMCS_MPAR = 3'h3,
      CMCS_SPAR = 3'h4
   } cmcs_mode_t;

   typedef enum logic [1:0] {
      CMCS_SETTLE = 2'h0,
      CMCS_LOAD = 2'h1,
      CMCS_DONE = 2'h2
   } cmcs_state_t;

   typedef enum logic [2:0] {
      CMCS_L1 = 3'h0,
      CMCS_L2 = 3'h1,
      CMCS_L4 = 3'h2,
      CMCS_L8 = 3'h3,
      CMCS_L16 = 3'h4
   } cmcs_lane_t;

   // pins as seen after the synchroniser
   typedef struct packed {
      logic [1:0] mode; // mode select pins
      logic ext_clk; // external master clock
      logic cfg_clk; // config clock from the far side
      logic sel_n; // chip select, low active
      logic wr_n; // read/write control, low = write
      logic [WORD_W-1:0] data; // data pins
   } cmcs_pins_t;

   // half period of the generated clock in system cycles, never below one
   function automatic logic [HALF_W-1:0] cmcs_half(input logic [RATE_W-1:0] mhz);
      int h;
      h = (mhz == '0) ? CLK_MHZ / (2 * DEFAULT_RATE_MHZ) : CLK_MHZ / (2 * int'(mhz));
      if (h < 1) begin
         h = 1;
      end
      return HALF_W'(h);
   endfunction

   localparam logic [HALF_W-1:0] INIT_HALF = cmcs_half(RATE_W'(INIT_RATE_MHZ));
endpackage

// file: core/cmcs_stream_if.sv
// word stream between the loader front end and its buffer
`timescale 1ns/1ps
`default_nettype none
interface cmcs_stream_if #(parameter int W = 16);
   logic [W-1:0] data; // word
   logic valid; // word offered
   logic ready; // word accepted
   modport src(output data, output valid, input ready);
   modport snk(input data, input valid, output ready);
endinterface
`default_nettype wire

// file: core/cmcs_top.sv
// configuration mode select, config clock direction and generation, word capture
`timescale 1ns/1ps
`default_nettype none
// Operation
// - mode taken from the two mode pins
// - five modes with their bus widths
// - serial and serial-flash share one code, parallel likewise
// - master drives config clock, oscillator or external
// - master paces the transfer with own clock
// - slave treats config clock as input only
// - master clock starts at one MHz
// - switch to programmed rate, default two MHz
// - oscillator off after load unless still needed
// - no pull-up before; release unless kept
// - borrowed pins go to user after load
// - JTAG path always available
// - slave parallel x8/x16 with select, write control
// - slave serial is clock plus one data
module cmcs_top
   import cmcs_pkg::*;
#(
   parameter int SETTLE_CYCLES = SYNC_SETTLE
) (
   input wire logic clk, // system clock, 25 MHz
   input wire logic rst, // sync reset, high
   input wire logic [1:0] mode_pins, // mode select pins
   input wire logic jtag_select, // load through the JTAG path
   input wire logic [1:0] bus_width, // data width select
   input wire logic use_external_clock, // master clock from external pin
   input wire logic external_master_clock, // external master clock pin
   input wire logic config_clock_in, // config clock pin, input side
   output logic config_clock_out, // config clock pin, output side
   output logic config_clock_oe_n, // config clock pin enable, low drives
   output logic config_clock_pullup_en, // pull-up on the config clock pin
   input wire logic user_config_clock_out, // user drive after release
   input wire logic user_config_clock_oe_n, // user enable after release
   input wire logic user_pullup_en, // user pull-up after release
   input wire logic [WORD_W-1:0] data_pins, // config data pins
   input wire logic chip_select_n, // slave parallel chip select
   input wire logic read_write_n, // slave parallel direction, low writes
   input wire logic [RATE_W-1:0] clock_rate_setting, // rate from bitstream, MHz
   input wire logic rate_load, // pulse: rate setting valid
   input wire logic config_done, // pulse: whole image received
   input wire logic upset_detection, // upset detection enabled
   input wire logic oscillator_clock_output, // oscillator output in use
   input wire logic suspend_internal_clock, // suspend wakes on internal clock
   input wire logic wakeup_active, // wakeup sequence in progress
   input wire logic encryption_enabled, // image is encrypted
   input wire logic keep_config_pins, // keep config pins after load
   output logic osc_enable, // internal oscillator on
   output logic pins_to_user, // borrowed pins handed to user logic
   output logic jtag_cfg_enable, // JTAG load path enabled
   output cmcs_mode_t config_mode, // selected mode
   output logic loading, // load in progress
   output logic busy, // word waiting, buffer full
   output logic [WORD_W-1:0] word_data, // assembled word
   output logic word_valid, // word offered
   input wire logic word_ready // word taken
);
   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 7) begin : g_chk
      $error("settle count must fit three bits");
   end
   localparam logic [2:0] SETTLE_LAST = 3'(SETTLE_CYCLES - 1);

   cmcs_pins_t s1, s2, s3; // synchroniser stages
   cmcs_pins_t filt; // pins after the two-of-two agreement
   cmcs_state_t state, next_state; // load sequence
   cmcs_mode_t mode; // mode latched for the whole load
   cmcs_lane_t lane; // bits taken per sample
   logic [2:0] settle; // cycles since reset release
   logic is_master; // device makes the clock
   logic is_slave; // far side makes the clock
   logic gen_level; // generated clock
   logic gen_rise; // generated clock rose
   logic gen_run; // let the generator advance
   logic config_clock_prev; // last filtered link clock
   logic link_rise; // link clock rose
   logic take; // sample the data pins now
   logic [WORD_W-1:0] acc, next_acc; // word being assembled
   logic [4:0] bit_cnt, next_cnt; // bits held in acc
   logic complete; // acc filled this sample
   logic [WORD_W-1:0] word; // finished word for the buffer
   logic push_valid; // finished word not yet taken
   logic keep_osc; // a feature still needs the oscillator

   cmcs_stream_if #(.W(WORD_W)) up(); // front end to buffer
   cmcs_stream_if #(.W(WORD_W)) down(); // buffer to user side

   // three flops on the mode, clock, select, write and data pins, no logic reads the first
   // kept out of reset so the pins have settled before the mode is latched
   always_ff @(posedge clk) begin
      s1 <= {mode_pins, external_master_clock, config_clock_in, chip_select_n,
             read_write_n, data_pins};
      s2 <= s1;
      s3 <= s2;
   end

   // a bit changes only when the second and third stage agree
   always_ff @(posedge clk) begin
      if (rst) begin
         filt <= '0;
      end else begin
         filt <= (s2 & s3) | (filt & (s2 | s3));
      end
   end

   // load sequence: settle, load until done, then stay done
   always_comb begin
      next_state = state;
      unique case (state)
         CMCS_SETTLE: if (settle == SETTLE_LAST) begin
            next_state = CMCS_LOAD;
         end
         CMCS_LOAD: if (config_done) begin
            next_state = CMCS_DONE;
         end
         CMCS_DONE: next_state = CMCS_DONE;
         default: next_state = CMCS_SETTLE; // unused code recovers
      endcase
   end

   // state and settle counter
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= CMCS_SETTLE;
         settle <= 3'h0;
      end else begin
         state <= next_state;
         if (state == CMCS_SETTLE) begin
            settle <= settle + 3'h1;
         end
      end
   end

   // mode latched once from the pins; later pin changes are ignored
   always_ff @(posedge clk) begin
      if (rst) begin
         mode <= CMCS_JTAG;
      end else if (state == CMCS_SETTLE && settle == SETTLE_LAST) begin
         if (jtag_select) begin
            mode <= CMCS_JTAG;
         end else begin
            unique case (filt.mode)
               MODE_PINS_MPAR: mode <= CMCS_MPAR; // plain or flash parallel
               MODE_PINS_MSER: mode <= CMCS_MSER; // plain or flash serial
               MODE_PINS_SPAR: mode <= CMCS_SPAR;
               MODE_PINS_SSER: mode <= CMCS_SSER;
            endcase
         end
      end
   end

   assign is_master = (mode == CMCS_MSER) || (mode == CMCS_MPAR);
   assign is_slave = (mode == CMCS_SSER) || (mode == CMCS_SPAR);
   assign loading = (state == CMCS_LOAD);
   assign config_mode = mode;
   assign jtag_cfg_enable = 1'b1; // never gated by the mode
   assign busy = push_valid && !up.ready;
   // stall the clock rather than drop a word from the flash
   assign gen_run = loading && is_master && !busy;

   cmcs_clk_gen u_gen (
      .clk(clk),
      .rst(rst),
      .run(gen_run),
      .use_ext(use_external_clock),
      .ext_level(filt.ext_clk),
      .rate_load(rate_load),
      .rate_mhz(clock_rate_setting),
      .clk_out(gen_level),
      .rise(gen_rise)
   );

   // config clock pin: master drives, slave and idle leave it alone
   always_comb begin
      config_clock_out = gen_level;
      config_clock_oe_n = 1'b1; // slave and idle do not drive until released to the user
      config_clock_pullup_en = 1'b0; // no pull-up until released
      if (state == CMCS_LOAD && is_master) begin
         config_clock_oe_n = 1'b0;
      end else if (state == CMCS_DONE && keep_config_pins) begin
         config_clock_oe_n = !is_master;
      end else if (state == CMCS_DONE) begin
         config_clock_out = user_config_clock_out;
         config_clock_oe_n = user_config_clock_oe_n;
         config_clock_pullup_en = user_pullup_en;
      end
   end

   // oscillator stays on only while some feature still uses it
   assign keep_osc = upset_detection || oscillator_clock_output || encryption_enabled
                   || (suspend_internal_clock && wakeup_active);
   always_ff @(posedge clk) begin
      if (rst) begin
         osc_enable <= 1'b1;
         pins_to_user <= 1'b0;
      end else begin
         osc_enable <= (next_state != CMCS_DONE) || keep_osc;
         pins_to_user <= (next_state == CMCS_DONE);
      end
   end

   // sample moments per mode; slave pace comes from the link clock
   assign link_rise = filt.cfg_clk && !config_clock_prev;
   always_comb begin
      unique case (mode)
         CMCS_MSER, CMCS_MPAR: take = loading && gen_rise;
         CMCS_SSER: take = loading && link_rise;
         CMCS_SPAR: take = loading && link_rise && !filt.sel_n && !filt.wr_n;
         default: take = 1'b0; // JTAG loads elsewhere, other codes unused
      endcase
   end

   // lane width from mode and width select
   always_comb begin
      unique case (mode)
         CMCS_MSER: lane = (bus_width == BW_X4) ? CMCS_L4 :
                           (bus_width == BW_X2) ? CMCS_L2 : CMCS_L1;
         CMCS_MPAR, CMCS_SPAR: lane = (bus_width == BW_X16) ? CMCS_L16 : CMCS_L8;
         default: lane = CMCS_L1; // one data line
      endcase
   end

   // shift the sampled lanes into the word, first bits most significant
   always_comb begin
      next_acc = acc;
      next_cnt = bit_cnt;
      if (take) begin
         unique case (lane)
            CMCS_L1: next_acc = {acc[14:0], filt.data[0]};
            CMCS_L2: next_acc = {acc[13:0], filt.data[1:0]};
            CMCS_L4: next_acc = {acc[11:0], filt.data[3:0]};
            CMCS_L8: next_acc = {acc[7:0], filt.data[7:0]};
            CMCS_L16: next_acc = filt.data;
            default: next_acc = acc;
         endcase
         unique case (lane)
            CMCS_L1: next_cnt = bit_cnt + 5'h01;
            CMCS_L2: next_cnt = bit_cnt + 5'h02;
            CMCS_L4: next_cnt = bit_cnt + 5'h04;
            CMCS_L8: next_cnt = bit_cnt + 5'h08;
            CMCS_L16: next_cnt = bit_cnt + 5'h10;
            default: next_cnt = bit_cnt;
         endcase
      end
   end
   assign complete = (next_cnt == WORD_BITS);

   // word assembly, cleared outside a load
   always_ff @(posedge clk) begin
      if (rst || !loading) begin
         acc <= '0;
         bit_cnt <= 5'h00;
         config_clock_prev <= 1'b0;
      end else begin
         acc <= next_acc;
         bit_cnt <= complete ? 5'h00 : next_cnt;
         config_clock_prev <= filt.cfg_clk;
      end
   end

   // finished word waits here until the buffer takes it; a new one wins
   always_ff @(posedge clk) begin
      if (rst) begin
         push_valid <= 1'b0;
         word <= '0;
      end else begin
         if (push_valid && up.ready) begin
            push_valid <= 1'b0;
         end
         if (complete) begin
            push_valid <= 1'b1;
            word <= next_acc;
         end
      end
   end
   assign up.data = word;
   assign up.valid = push_valid;

   cmcs_buf #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
      .clk(clk),
      .rst(rst),
      .fill(up),
      .drain(down)
   );
   assign word_data = down.data;
   assign word_valid = down.valid;
   assign down.ready = word_ready;

   default clocking tdc @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wide_take;
      take && lane == CMCS_L16;
   endsequence
   sequence s_finish;
      loading && config_done;
   endsequence
   jtag_always_a: assert property (jtag_cfg_enable)
      else $error("jtag path disabled");
   slave_no_drive_a: assert property (loading && is_slave |-> config_clock_oe_n)
      else $error("slave mode drives the config clock");
   master_drive_a: assert property (loading && is_master
                                    |-> !config_clock_oe_n && config_clock_out == gen_level)
      else $error("master mode not driving the config clock");
   mode_hold_a: assert property (state != CMCS_SETTLE |=> $stable(mode))
      else $error("mode changed after it was latched");
   osc_off_a: assert property (pins_to_user && !$past(keep_osc) |-> !osc_enable)
      else $error("oscillator left running after load");
   pin_release_a: assert property (pins_to_user && !keep_config_pins
      |-> config_clock_oe_n == user_config_clock_oe_n && config_clock_out == user_config_clock_out)
      else $error("config clock pin not released");
   load_finish_a: assert property (s_finish |=> pins_to_user && !loading)
      else $error("borrowed pins not handed over");
   wide_word_a: assert property (s_wide_take |=> up.valid && up.data == $past(filt.data))
      else $error("wide sample did not form a word");
endmodule
`default_nettype wire

// file: dv/cmcs_host.sv
// slave serial host model: link clock plus one data line
`timescale 1ns/1ps
`default_nettype none
module cmcs_host (
   input wire logic start, // rise sends one word
   input wire logic [15:0] word, // word to send
   output logic link_clk, // link clock, still between frames
   output logic sdata, // serial data
   output logic sent // word finished
);
   initial begin
      link_clk = 1'b0;
      sdata = 1'b0;
      sent = 1'b0;
   end
   // msb first, data moves only while the clock is low
   always @(posedge start) begin
      for (int i = 15; i >= 0; i--) begin
         sdata = word[i];
         #160 link_clk = 1'b1;
         #160 link_clk = 1'b0;
      end
      sdata = ~sdata; // released line shows no stale bit
      sent = 1'b1;
   end
endmodule
`default_nettype wire

// file: dv/testbench.sv
// bench: mode decode, slave word capture, master clock rates, pin release
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cmcs_pkg::*;
   logic clk = 1'b0, rst = 1'b1, sdata, sent, start = 1'b0; // clock, reset, host
   logic jtag_select = 1'b0, use_external_clock = 1'b0, external_master_clock = 1'b0;
   logic config_clock_in, user_config_clock_out = 1'b0, user_config_clock_oe_n = 1'b0;
   logic user_pullup_en = 1'b1, chip_select_n = 1'b1, read_write_n = 1'b1, rate_load = 1'b0;
   logic config_done = 1'b0, upset_detection = 1'b0, oscillator_clock_output = 1'b0;
   logic suspend_internal_clock = 1'b0, wakeup_active = 1'b0, encryption_enabled = 1'b0;
   logic keep_config_pins = 1'b0, word_ready = 1'b0, config_clock_out, config_clock_oe_n;
   logic [1:0] mode_pins = 2'h0, bus_width = 2'h0; // pins and width
   logic [RATE_W-1:0] clock_rate_setting = 8'h00; // zero names the default rate
   logic config_clock_pullup_en, osc_enable, pins_to_user, jtag_cfg_enable, loading, busy;
   logic word_valid; // word offered
   logic [WORD_W-1:0] word_data; // captured word
   logic [WORD_W-1:0] par_word = 16'h0000; // parallel lanes from the host
   wire logic [WORD_W-1:0] data_pins = par_word | {15'h0000, sdata}; // serial on lane 0
   cmcs_mode_t config_mode; // decoded mode
   int miscompares = 0, total_checks = 0, cycles = 0;
   cmcs_mode_t modes [5] = '{CMCS_MPAR, CMCS_MSER, CMCS_SPAR, CMCS_SSER, CMCS_JTAG};
   always #20 clk = ~clk; // 25 MHz
   cmcs_top dut (.*);
   cmcs_host host (.start(start), .word(16'hA5C3), .link_clk(config_clock_in),
      .sdata(sdata), .sent(sent));
   // inputs always move the same small delay after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // pins set well before release so the synchroniser settles
   task automatic boot(input logic [1:0] m, input logic j);
      rst = 1'b1;
      mode_pins = m; // held steady through the load
      jtag_select = j;
      tick(16);
      rst = 1'b0;
      tick(6);
   endtask
   // high time of the generated clock in system cycles
   task automatic hi(input logic [15:0] e);
      logic [15:0] n;
      n = 16'h0000;
      while (config_clock_out !== 1'b1) tick(1);
      while (config_clock_out === 1'b1) begin
         tick(1);
         n++;
      end
      chk(n, e);
   endtask
   task automatic results;
      if (miscompares == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // hang guard, far above the few hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         results;
      end
   end
   initial begin
      tick(2);
      chk({osc_enable, jtag_cfg_enable, config_clock_oe_n, config_clock_pullup_en, pins_to_user}, 16'h001C);
      for (int i = 0; i < 5; i++) begin
         boot(i[1:0], i == 4);
         chk(16'({config_mode, jtag_cfg_enable}), 16'({modes[i], 1'b1}));
         if (i < 4) chk(16'(config_clock_oe_n), 16'(i > 1));
      end
      boot(2'h3, 1'b0);
      start = 1'b1;
      while (sent !== 1'b1 || word_valid !== 1'b1) tick(1);
      chk(word_data, 16'hA5C3);
      start = 1'b0;
      word_ready = 1'b1;
      tick(2);
      chk(16'(word_valid), 16'h0000);
      config_done = 1'b1;
      tick(1);
      config_done = 1'b0;
      tick(1);
      chk({pins_to_user, osc_enable, loading, config_clock_oe_n, config_clock_pullup_en}, 16'h0011);
      // slave parallel x16: a word per link edge; a stalled user side raises busy
      boot(2'h2, 1'b0);
      {bus_width, chip_select_n, read_write_n, word_ready} = 5'h08;
      par_word = 16'h5A3C;
      start = 1'b1;
      while (word_valid !== 1'b1) tick(1);
      chk(word_data, 16'h5A3D);
      tick(20);
      chk(16'(busy), 16'h0001);
      word_ready = 1'b1;
      // master: kept pins and upset detection hold drive and oscillator
      user_config_clock_oe_n = 1'b1;
      keep_config_pins = 1'b1;
      upset_detection = 1'b1;
      boot(2'h1, 1'b0);
      rate_load = 1'b1;
      tick(1);
      rate_load = 1'b0;
      hi(16'h000C);
      hi(16'h0006);
      config_done = 1'b1;
      tick(1);
      config_done = 1'b0;
      tick(1);
      chk({pins_to_user, osc_enable, config_clock_oe_n}, 16'h0006);
      results;
   end
endmodule
`default_nettype wire
